//--- hdl/alc_cfg.svh
// constants for the serial transport stream line coding block
`ifndef ALC_CFG_SVH
`define ALC_CFG_SVH

`define ALC_LINE_MBAUD  270
`define ALC_LINE_PPM    100
`define ALC_WORD_BITS   10
`define ALC_SLOT_LAST   4'h9
`define ALC_SYNC_MIN    2'h2
`define ALC_PKT_LEN     8'hBC
`define ALC_PKT_LEN_RS  8'hCC
`define ALC_K285_BYTE   8'hBC
`define ALC_COMMA_NEG   10'h17C
`define ALC_COMMA_POS   10'h283
`define ALC_ERR_LIMIT   3'h4

`endif

//--- hdl/alc_pkg.sv
// types and code tables for the serial transport stream line coding block
package alc_pkg;

  typedef enum logic {ALC_HUNT, ALC_LOCK} alc_rx_st_t;

  // 6-bit sub-block, written abcdei with a in the msb, negative disparity column
  function automatic logic [5:0] alc_tab6(input logic [4:0] x);
    logic [5:0] t;
    case (x)
      5'h00: t = 6'h27; 5'h01: t = 6'h1D; 5'h02: t = 6'h2D; 5'h03: t = 6'h31;
      5'h04: t = 6'h35; 5'h05: t = 6'h29; 5'h06: t = 6'h19; 5'h07: t = 6'h38;
      5'h08: t = 6'h39; 5'h09: t = 6'h25; 5'h0A: t = 6'h15; 5'h0B: t = 6'h34;
      5'h0C: t = 6'h0D; 5'h0D: t = 6'h2C; 5'h0E: t = 6'h1C; 5'h0F: t = 6'h17;
      5'h10: t = 6'h1B; 5'h11: t = 6'h23; 5'h12: t = 6'h13; 5'h13: t = 6'h32;
      5'h14: t = 6'h0B; 5'h15: t = 6'h2A; 5'h16: t = 6'h1A; 5'h17: t = 6'h3A;
      5'h18: t = 6'h33; 5'h19: t = 6'h26; 5'h1A: t = 6'h16; 5'h1B: t = 6'h36;
      5'h1C: t = 6'h0E; 5'h1D: t = 6'h2E; 5'h1E: t = 6'h1E; default: t = 6'h2B;
    endcase
    return t;
  endfunction

  // 4-bit sub-block, written fghj with f in the msb, negative disparity column
  function automatic logic [3:0] alc_tab4(input logic [2:0] y);
    logic [3:0] t;
    case (y)
      3'h0: t = 4'hB; 3'h1: t = 4'h9; 3'h2: t = 4'h5; 3'h3: t = 4'hC;
      3'h4: t = 4'hD; 3'h5: t = 4'hA; 3'h6: t = 4'h6; default: t = 4'hE;
    endcase
    return t;
  endfunction

endpackage

//--- hdl/alc_enc.sv
// byte to ten-bit word encoder with running disparity
`timescale 1ns/100ps
module alc_enc (
  // byte in
  input  wire logic [7:0] data_i,
  input  wire logic       ctrl_i,
  input  wire logic       rd_i,
  // word out, bit 0 is sent first
  output logic      [9:0] code_o,
  output logic            rd_o
);

  wire logic [4:0] x_w    = data_i[4:0];
  wire logic [2:0] y_w    = data_i[7:5];
  // the control path only ever carries the comma character
  wire logic [5:0] t6_w   = ctrl_i ? 6'h0F : alc_pkg::alc_tab6(x_w);
  wire logic       unb6_w = ($countones(t6_w) != 3);
  wire logic       flip6_w = rd_i & (unb6_w | (t6_w == 6'h38));
  wire logic [5:0] six_w  = flip6_w ? ~t6_w : t6_w;
  wire logic       rd_mid_w = rd_i ^ unb6_w;
  // alternate 7 avoids a run of five equal bits across the sub-block seam
  wire logic       alt7_w = (y_w == 3'h7) &
                            ((!rd_mid_w & ((x_w == 5'h11) | (x_w == 5'h12) | (x_w == 5'h14))) |
                             (rd_mid_w & ((x_w == 5'h0B) | (x_w == 5'h0D) | (x_w == 5'h0E))));
  wire logic [3:0] t4_w   = alt7_w ? 4'h7 : alc_pkg::alc_tab4(y_w);
  wire logic       unb4_w = ($countones(t4_w) != 2);
  wire logic       flip4_w = rd_mid_w & (unb4_w | (t4_w == 4'hC));
  wire logic [3:0] kfour_w = rd_mid_w ? 4'hA : 4'h5;
  wire logic [3:0] four_w = ctrl_i ? kfour_w : (flip4_w ? ~t4_w : t4_w);

  assign code_o = {four_w[0], four_w[1], four_w[2], four_w[3],
                   six_w[0], six_w[1], six_w[2], six_w[3], six_w[4], six_w[5]};
  assign rd_o   = ctrl_i ? rd_mid_w : (rd_mid_w ^ unb4_w);

endmodule

//--- hdl/alc_link.sv
// transmit and receive line coding and alignment for the serial transport stream link
`timescale 1ns/100ps
`include "alc_cfg.svh"

module alc_link (
  // clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  // transmit byte source
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_valid_i,
  input  wire logic       tx_rs_mode_i,
  output logic            tx_ready_o,
  // transmit line
  output logic            tx_ser_o,
  output logic            tx_word_stb_o,
  // receive line
  input  wire logic       rx_ser_i,
  // receive byte sink
  output logic      [7:0] rx_data_o,
  output logic            rx_valid_o,
  output logic            rx_err_o,
  output logic            rx_locked_o
);

  ////////////////////////////////////////////////////////////////////////////
  // transmit side

  logic [3:0] div_r;
  logic [9:0] tx_sh_r;
  logic       rd_r;
  logic [1:0] sync_cnt_r;
  logic [7:0] idx_r;
  logic [9:0] enc_code_w;
  logic       enc_rd_w;

  wire logic       slot_w    = (div_r == `ALC_SLOT_LAST);
  wire logic [7:0] pkt_last_w = (tx_rs_mode_i ? `ALC_PKT_LEN_RS : `ALC_PKT_LEN) - 8'h01;
  wire logic       gate_ok_w = (idx_r != 8'h00) | (sync_cnt_r >= `ALC_SYNC_MIN);
  wire logic       take_w    = slot_w & tx_valid_i & gate_ok_w;

  assign tx_ready_o    = slot_w & gate_ok_w;
  assign tx_word_stb_o = slot_w;
  assign tx_ser_o      = tx_sh_r[0];

  alc_enc u_enc (
    .data_i (take_w ? tx_data_i : `ALC_K285_BYTE),
    .ctrl_i (~take_w),
    .rd_i   (rd_r),
    .code_o (enc_code_w),
    .rd_o   (enc_rd_w)
  );

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_r <= 4'h0;
    end else begin
      div_r <= slot_w ? 4'h0 : div_r + 4'h1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_sh_r <= `ALC_COMMA_NEG;
      // the reset word is a negative comma, so the line leaves reset at positive disparity
      rd_r    <= 1'b1;
    end else if (slot_w) begin
      tx_sh_r <= enc_code_w;
      rd_r    <= enc_rd_w;
    end else begin
      tx_sh_r <= {tx_sh_r[0], tx_sh_r[9:1]};
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_cnt_r <= 2'h0;
      idx_r      <= 8'h00;
    end else if (take_w) begin
      sync_cnt_r <= 2'h0;
      idx_r      <= (idx_r >= pkt_last_w) ? 8'h00 : idx_r + 8'h01;
    end else if (slot_w && sync_cnt_r != 2'h3) begin
      sync_cnt_r <= sync_cnt_r + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive side

  alc_pkg::alc_rx_st_t st_r;
  logic [9:0] rx_sh_r;
  logic [3:0] bit_cnt_r;
  logic [2:0] err_cnt_r;
  logic [4:0] dec_x;
  logic [2:0] dec_y;
  logic       ok6;
  logic       ok4;

  wire logic comma_w = (rx_sh_r == `ALC_COMMA_NEG) | (rx_sh_r == `ALC_COMMA_POS);
  wire logic wb_w    = comma_w | ((st_r == alc_pkg::ALC_LOCK) & (bit_cnt_r == `ALC_SLOT_LAST));
  wire logic [5:0] rx6_w = {rx_sh_r[0], rx_sh_r[1], rx_sh_r[2], rx_sh_r[3], rx_sh_r[4], rx_sh_r[5]};
  wire logic [3:0] rx4_w = {rx_sh_r[6], rx_sh_r[7], rx_sh_r[8], rx_sh_r[9]};
  wire logic code_err_w  = wb_w & ~comma_w & ~(ok6 & ok4);

  always_comb begin
    logic [5:0] t6;
    logic [3:0] t4;
    t6    = 6'h00;
    t4    = 4'h0;
    dec_x = 5'h00;
    dec_y = 3'h0;
    ok6   = 1'b0;
    ok4   = 1'b0;
    for (int i = 0; i < 32; i++) begin
      t6 = alc_pkg::alc_tab6(i[4:0]);
      if (rx6_w == t6 || (rx6_w == ~t6 && ($countones(t6) != 3 || t6 == 6'h38))) begin
        dec_x = i[4:0];
        ok6   = 1'b1;
      end
    end
    for (int j = 0; j < 8; j++) begin
      t4 = alc_pkg::alc_tab4(j[2:0]);
      if (rx4_w == t4 || (rx4_w == ~t4 && ($countones(t4) != 2 || t4 == 4'hC))) begin
        dec_y = j[2:0];
        ok4   = 1'b1;
      end
    end
    if (rx4_w == 4'h7 || rx4_w == 4'h8) begin
      dec_y = 3'h7;
      ok4   = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_sh_r   <= 10'h000;
      bit_cnt_r <= 4'h0;
    end else begin
      rx_sh_r   <= {rx_ser_i, rx_sh_r[9:1]};
      bit_cnt_r <= wb_w ? 4'h0 : bit_cnt_r + 4'h1;
    end
  end

  // repeated bad words mean the boundary is wrong, so go back to hunting
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r      <= alc_pkg::ALC_HUNT;
      err_cnt_r <= 3'h0;
    end else begin
      case (st_r)
        alc_pkg::ALC_HUNT: begin
          err_cnt_r <= 3'h0;
          if (comma_w) begin
            st_r <= alc_pkg::ALC_LOCK;
          end
        end
        alc_pkg::ALC_LOCK: begin
          if (code_err_w) begin
            err_cnt_r <= err_cnt_r + 3'h1;
            if (err_cnt_r + 3'h1 >= `ALC_ERR_LIMIT) begin
              st_r <= alc_pkg::ALC_HUNT;
            end
          end else if (wb_w) begin
            err_cnt_r <= 3'h0;
          end
        end
        default: st_r <= alc_pkg::ALC_HUNT;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_data_o  <= 8'h00;
      rx_valid_o <= 1'b0;
      rx_err_o   <= 1'b0;
    end else begin
      rx_valid_o <= wb_w & ~comma_w & ok6 & ok4 & (st_r == alc_pkg::ALC_LOCK);
      rx_err_o   <= code_err_w & (st_r == alc_pkg::ALC_LOCK);
      if (wb_w && !comma_w) begin
        rx_data_o <= {dec_y, dec_x};
      end
    end
  end

  assign rx_locked_o = (st_r == alc_pkg::ALC_LOCK);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_slot_period: assert property (slot_w |=> !slot_w [*8] ##1 !slot_w ##1 slot_w)
    else $error("word slot period is not ten cycles");
  a_ready_in_slot: assert property (tx_ready_o |-> slot_w)
    else $error("ready outside a word slot");
  a_sync_before_pkt: assert property (take_w && idx_r == 8'h00 |-> !$past(take_w, 10) && !$past(take_w, 20))
    else $error("packet start without two sync words");
  a_fill_sync_word: assert property (slot_w && !take_w |=> tx_sh_r == 10'h17C || tx_sh_r == 10'h283)
    else $error("empty slot did not carry a comma");
  a_comma_polarity: assert property (slot_w && !take_w && !rd_r |=> tx_sh_r == 10'h17C)
    else $error("comma polarity does not match disparity");
  a_word_balance: assert property (slot_w && !rd_r |=> $countones(tx_sh_r) >= 5 && $countones(tx_sh_r) <= 6)
    else $error("word breaks disparity balance");
  a_rd_follows: assert property (slot_w && $countones(enc_code_w) != 5 |=> rd_r != $past(rd_r))
    else $error("running disparity did not flip");
  a_sync_dropped: assert property (comma_w |=> !rx_valid_o)
    else $error("sync word forwarded as data");
  a_hunt_silent: assert property (st_r == alc_pkg::ALC_HUNT |=> !rx_valid_o)
    else $error("data forwarded while hunting");
  a_lock_on_comma: assert property (st_r == alc_pkg::ALC_HUNT && comma_w |=> rx_locked_o ##9 wb_w)
    else $error("comma did not fix the word boundary");

endmodule

//--- dv/alc_far_model.sv
// far-end serial equipment: comma-filled sender and comma-aligned receiver
`timescale 1ns/100ps
`include "alc_cfg.svh"
module alc_far_model (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  // serial lines
  input  wire logic ser_i,
  output logic      ser_o
);
  bit         tq[$];
  logic [9:0] got[$];
  int         gap[$];
  logic [9:0] sh = 10'h000;
  logic [9:0] nsh;
  int         cnt;
  int         run;
  bit         lock;
  bit         rd;

  initial ser_o = 1'b0;

  task automatic push_word(input logic [9:0] w);
    for (int i = 0; i < 10; i++) tq.push_back(w[i]);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // fixed rate, idle slots carry disparity-matched commas
  always @(posedge ref_clk_i) begin
    if (tq.size() == 0) begin
      push_word(rd ? `ALC_COMMA_POS : `ALC_COMMA_NEG);
      rd = !rd;
    end
    // bits leave uninverted, bit a first
    ser_o <= tq.pop_front();
  end

  ////////////////////////////////////////////////////////////////////////////
  // hunt a comma, then cut words and set commas aside
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock = 1'b0;
      cnt = 0;
      run = 0;
      got.delete();
      gap.delete();
    end else begin
      nsh = {ser_i, sh[9:1]};
      sh <= nsh;
      if (nsh == `ALC_COMMA_NEG || nsh == `ALC_COMMA_POS) begin
        lock = 1'b1;
        cnt = 0;
        run++;
      end else if (lock) begin
        cnt++;
        if (cnt == 10) begin
          cnt = 0;
          got.push_back(nsh);
          gap.push_back(run);
          run = 0;
        end
      end
    end
  end
endmodule

//--- dv/alc_link_tb.sv
// self-checking bench for the serial line coding block
`timescale 1ns/100ps
module alc_link_tb;
  logic        ref_clk_i;
  logic        rst_b_i = 1'b0;
  logic [7:0]  tx_data_i = 8'h00;
  logic        tx_valid_i = 1'b0;
  logic        tx_rs_mode_i = 1'b0;
  logic        tx_ready_o;
  logic        tx_ser_o;
  logic        tx_word_stb_o;
  logic        rx_ser_i;
  logic [7:0]  rx_data_o;
  logic        rx_valid_o;
  logic        rx_err_o;
  logic        rx_locked_o;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          last = 0;
  int          nerr = 0;
  int          unl = 0;
  int          bal = -1;
  int          bmax = 0;
  logic [7:0]  rxq[$];
  // neutral words, the same in both disparity columns
  logic [17:0] rows [4] = '{{8'h23, 10'h263}, {8'h45, 10'h2A5}, {8'hCA, 10'h1AA}, {8'h2C, 10'h26C}};

  alc_link dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .tx_data_i(tx_data_i), .tx_valid_i(tx_valid_i),
    .tx_rs_mode_i(tx_rs_mode_i), .tx_ready_o(tx_ready_o), .tx_ser_o(tx_ser_o), .tx_word_stb_o(tx_word_stb_o),
    .rx_ser_i(rx_ser_i), .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_err_o(rx_err_o),
    .rx_locked_o(rx_locked_o));
  alc_far_model far (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .ser_i(tx_ser_o), .ser_o(rx_ser_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic reset_dut();
    rst_b_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    last = 0;
  endtask

  // source holds each byte until a slot takes it
  task automatic send(input int n, input logic mode, input int space);
    tx_rs_mode_i <= mode;
    for (int i = 0; i < n; i++) begin
      tx_data_i <= rows[i % 4][17:10];
      tx_valid_i <= 1'b1;
      @(posedge ref_clk_i);
      while (!(tx_word_stb_o === 1'b1 && tx_ready_o === 1'b1)) @(posedge ref_clk_i);
      if (space > 0) begin
        tx_valid_i <= 1'b0;
        repeat (space) @(posedge ref_clk_i);
      end
    end
    tx_valid_i <= 1'b0;
    repeat (40) @(posedge ref_clk_i);
  endtask

  task automatic check_tx(input int n, input int plen, input int space);
    chk(far.got.size(), n);
    for (int i = 0; i < far.got.size(); i++) begin
      chk(far.got[i], rows[i % 4][9:0]);
      if (i % plen == 0) chk(far.gap[i] >= 2, 1);
      else chk(far.gap[i] >= 1, space > 0);
    end
  endtask

  always @(posedge ref_clk_i) begin
    cyc++;
    // running digital sum of the transmit line, restarting negative at reset
    if (rst_b_i !== 1'b1) bal = -1;
    else bal += (tx_ser_o === 1'b1) ? 1 : -1;
    if (bal > bmax) bmax = bal;
    if (-bal > bmax) bmax = -bal;
    if (rx_valid_o === 1'b1) rxq.push_back(rx_data_o);
    if (rx_err_o === 1'b1) nerr++;
    if (rx_locked_o === 1'b0) unl++;
    if (tx_word_stb_o === 1'b1) begin
      if (last > 0) chk(cyc - last, 10);
      last = cyc;
    end
  end

  // hang guard, well above the few thousand cycles needed
  always @(posedge ref_clk_i) begin
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_dut();
    for (int m = 0; m < 2; m++) begin
      send(190 + 16 * m, m[0], 0);
      check_tx(190 + 16 * m, 188 + 16 * m, 0);
      reset_dut();
    end
    send(3, 1'b0, 25);
    check_tx(3, 188, 25);
    // a burst of stray bits forces the receiver to realign; the straddling word is undecodable
    @(negedge ref_clk_i);
    for (int i = 0; i < 5; i++) far.tq.push_back(1'b0);
    repeat (60) @(posedge ref_clk_i);
    chk(rx_locked_o, 1'b1);
    chk(rxq.size(), 0);
    for (int i = 0; i < 4; i++) begin
      @(negedge ref_clk_i);
      far.push_word(rows[i][9:0]);
      repeat (40) @(posedge ref_clk_i);
      chk(rxq.size(), 1);
      chk(rxq.pop_front(), rows[i][17:10]);
    end
    @(negedge ref_clk_i);
    nerr = 0;
    unl = 0;
    for (int i = 0; i < 4; i++) far.push_word(10'h000);
    repeat (80) @(posedge ref_clk_i);
    chk(nerr, 4);
    chk(unl > 0, 1);
    chk(rx_locked_o, 1'b1);
    chk(rxq.size(), 0);
    chk(bmax <= 3, 1);
    results();
  end
endmodule
